// file: shared/adc_readout_pkg.sv
// constants and types shared by the converter readout design
package adc_readout_pkg;

  // -----------------------------------------------------------------
  // clock and conversion timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MOD_DIV        = 6;
  localparam int OSR            = 64;
  localparam int CONV_CYCLES    = MOD_DIV * OSR;
  localparam int SETTLE_RESULTS = 5;

  // -----------------------------------------------------------------
  // filter and result format
  // -----------------------------------------------------------------
  localparam int SINC_ORDER  = 5;
  localparam int RESULT_BITS = 24;
  localparam int ACC_BITS    = 1 + SINC_ORDER * $clog2(OSR);

  // -----------------------------------------------------------------
  // shift clock hold times
  // -----------------------------------------------------------------
  localparam int SYNC_HOLD_US      = 10;
  localparam int PDOWN_HOLD_US     = 60;
  localparam int SYNC_HOLD_CYCLES  = SYNC_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int PDOWN_HOLD_CYCLES = PDOWN_HOLD_US * 1000 / CLK_PERIOD_NS;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic       PIN_IDLE   = 1'b1;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [3:0] SEL_RESET  = 4'h1;

  typedef enum logic [3:0] {
    ST_SETTLE = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_HOLD   = 4'b0100,
    ST_SLEEP  = 4'b1000
  } conv_state_t;

endpackage

// file: verilog/sinc5_decimator.sv
// fifth-order sinc decimator turning the modulator bitstream into words
`timescale 1ns/10ps
`default_nettype none
module sinc5_decimator
  import adc_readout_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic                   restart,
  input  wire logic                   sample_stb,
  input  wire logic                   bit_in,
  output logic [RESULT_BITS-1:0]      result,
  output logic                        result_stb
);

  localparam logic [ACC_BITS-1:0] MID = ACC_BITS'(1) << (ACC_BITS - 2);

  logic [ACC_BITS-1:0]    integ_reg [SINC_ORDER];
  logic [ACC_BITS-1:0]    integ_next[SINC_ORDER];
  logic [ACC_BITS-1:0]    dly_reg   [SINC_ORDER];
  logic [ACC_BITS-1:0]    dly_next  [SINC_ORDER];
  logic [5:0]             dec_reg;
  logic [5:0]             dec_next;
  logic [RESULT_BITS-1:0] result_next;
  logic                   stb_next;

  // -----------------------------------------------------------------
  // unsigned filter sum to two's complement word, saturating
  // -----------------------------------------------------------------
  function automatic logic [RESULT_BITS-1:0] to_code(
    input logic [ACC_BITS-1:0] v);
    logic [ACC_BITS-1:0] s;
    s = v - MID;
    if (v >= (MID << 1)) begin
      to_code = {1'b0, {(RESULT_BITS-1){1'b1}}};
    end else begin
      to_code = s[ACC_BITS-2 -: RESULT_BITS];
    end
  endfunction

  // -----------------------------------------------------------------
  // integrators at modulator rate, combs at output rate
  // -----------------------------------------------------------------
  always_comb begin
    logic [ACC_BITS-1:0] diff;
    diff        = '0;
    integ_next  = integ_reg;
    dly_next    = dly_reg;
    dec_next    = dec_reg;
    result_next = result;
    stb_next    = 1'b0;
    if (restart) begin
      integ_next = '{default: '0};
      dly_next   = '{default: '0};
      dec_next   = 6'h0;
    end else if (sample_stb) begin
      integ_next[0] = integ_reg[0] + ACC_BITS'(bit_in);
      for (int i = 1; i < SINC_ORDER; i++) begin
        integ_next[i] = integ_reg[i] + integ_reg[i-1];
      end
      dec_next = dec_reg + 6'h1;
      if (dec_reg == 6'(OSR - 1)) begin
        diff = integ_reg[SINC_ORDER-1];
        for (int i = 0; i < SINC_ORDER; i++) begin
          dly_next[i] = diff;
          diff        = diff - dly_reg[i];
        end
        result_next = to_code(diff);
        stb_next    = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_reg  <= '{default: '0};
      dly_reg    <= '{default: '0};
      dec_reg    <= 6'h0;
      result     <= '0;
      result_stb <= 1'b0;
    end else if (clk_en) begin
      integ_reg  <= integ_next;
      dly_reg    <= dly_next;
      dec_reg    <= dec_next;
      result     <= result_next;
      result_stb <= stb_next;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  word_per_osr_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && stb_next) |-> (sample_stb && dec_reg == 6'(OSR - 1)))
    else $error("result produced off the decimation boundary");

endmodule
`default_nettype wire

// file: verilog/adc_readout.sv
// conversion control, channel mux and serial readout of the converter
`timescale 1ns/10ps
`default_nettype none
module adc_readout
  import adc_readout_pkg::*;
#(
  parameter int SYNC_HOLD  = SYNC_HOLD_CYCLES,
  parameter int PDOWN_HOLD = PDOWN_HOLD_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       shift_clk_pin,
  input  wire logic       channel_pick_lsb,
  input  wire logic       channel_pick_msb,
  input  wire logic       modulator_bit,
  output logic            result_out_ready_pin,
  output logic [3:0]      analog_input_select,
  output logic            modulator_sample,
  output logic            modulator_reset,
  output logic            power_down
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic                   sclk_s1_reg;
  logic                   sclk_s2_reg;
  logic                   sclk_s3_reg;
  logic                   sclk_stable_reg;
  logic                   sclk_stable_next;
  logic [1:0]             chan_s1_reg;
  logic [1:0]             chan_s2_reg;
  logic [1:0]             chan_s3_reg;
  logic [1:0]             chan_stable_reg;
  logic [1:0]             chan_stable_next;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   chan_change;

  conv_state_t            state_reg;
  conv_state_t            state_next;
  logic [2:0]             div_reg;
  logic [2:0]             div_next;
  logic [2:0]             settle_reg;
  logic [2:0]             settle_next;
  logic [15:0]            hold_reg;
  logic [15:0]            hold_next;
  logic                   restart_reg;
  logic                   restart_next;
  logic                   present_reg;
  logic                   present_next;
  logic                   mod_stb_next;
  logic                   mod_rst_next;
  logic                   pdown_next;
  logic [3:0]             select_next;
  logic                   running;

  logic [RESULT_BITS-1:0] filt_result;
  logic                   filt_stb;

  logic [RESULT_BITS-1:0] shift_reg;
  logic [RESULT_BITS-1:0] shift_next;
  logic                   pin_next;
  logic [4:0]             bit_reg;
  logic [4:0]             bit_next;
  logic                   loaded_reg;
  logic                   loaded_next;
  logic                   shift_msb;

  // -----------------------------------------------------------------
  // channel code to one-hot input select
  // -----------------------------------------------------------------
  function automatic logic [3:0] chan_decode(input logic [1:0] code);
    chan_decode = 4'h1 << code;
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_s1_reg <= CHAN_RESET;
    end else if (clk_en) begin
      chan_s1_reg <= {channel_pick_msb, channel_pick_lsb};
    end
  end

  always_comb begin
    sclk_stable_next = sclk_stable_reg;
    chan_stable_next = chan_stable_reg;
    if (sclk_s2_reg == sclk_s3_reg) begin
      sclk_stable_next = sclk_s3_reg;
    end
    if (chan_s2_reg == chan_s3_reg) begin
      chan_stable_next = chan_s3_reg;
    end
    sclk_rise   = sclk_stable_next && !sclk_stable_reg;
    sclk_fall   = !sclk_stable_next && sclk_stable_reg;
    chan_change = chan_stable_next != chan_stable_reg;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s1_reg     <= 1'b0;
      sclk_s2_reg     <= 1'b0;
      sclk_s3_reg     <= 1'b0;
      sclk_stable_reg <= 1'b0;
      chan_s2_reg     <= CHAN_RESET;
      chan_s3_reg     <= CHAN_RESET;
      chan_stable_reg <= CHAN_RESET;
    end else if (clk_en) begin
      sclk_s1_reg     <= shift_clk_pin;
      sclk_s2_reg     <= sclk_s1_reg;
      sclk_s3_reg     <= sclk_s2_reg;
      sclk_stable_reg <= sclk_stable_next;
      chan_s2_reg     <= chan_s1_reg;
      chan_s3_reg     <= chan_s2_reg;
      chan_stable_reg <= chan_stable_next;
    end
  end

  // -----------------------------------------------------------------
  // conversion control
  // -----------------------------------------------------------------
  assign running = (state_reg == ST_SETTLE) || (state_reg == ST_RUN);

  always_comb begin
    state_next   = state_reg;
    div_next     = div_reg;
    settle_next  = settle_reg;
    restart_next = 1'b0;
    present_next = 1'b0;
    mod_stb_next = 1'b0;
    hold_next    = 16'h0;
    if (sclk_stable_reg && hold_reg != 16'hffff) begin
      hold_next = hold_reg + 16'h1;
    end
    if (running) begin
      mod_stb_next = div_reg == 3'(MOD_DIV - 1);
      div_next     = mod_stb_next ? 3'h0 : div_reg + 3'h1;
    end
    case (state_reg)
      ST_SETTLE: begin
        if (filt_stb) begin
          settle_next = settle_reg + 3'h1;
          if (settle_reg == 3'(SETTLE_RESULTS - 1)) begin
            present_next = 1'b1;
            settle_next  = 3'h0;
            state_next   = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        present_next = filt_stb;
      end
      ST_HOLD: begin
        if (!sclk_stable_reg) begin
          state_next   = ST_SETTLE;
          restart_next = 1'b1;
        end else if (hold_reg == 16'(PDOWN_HOLD - 1)) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!sclk_stable_reg) begin
          state_next   = ST_SETTLE;
          restart_next = 1'b1;
        end
      end
      default: begin
        state_next   = ST_SETTLE;
        restart_next = 1'b1;
      end
    endcase
    if (running && chan_change) begin
      state_next   = ST_SETTLE;
      restart_next = 1'b1;
    end
    if (running && sclk_stable_reg && hold_reg == 16'(SYNC_HOLD - 1)) begin
      state_next   = ST_HOLD;
      restart_next = 1'b1;
    end
    if (restart_next) begin
      present_next = 1'b0;
      settle_next  = 3'h0;
      div_next     = 3'h0;
      mod_stb_next = 1'b0;
    end
    mod_rst_next = state_next == ST_HOLD;
    pdown_next   = state_next == ST_SLEEP;
    select_next  = chan_decode(chan_stable_next);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= ST_SETTLE;
      div_reg             <= 3'h0;
      settle_reg          <= 3'h0;
      hold_reg            <= 16'h0;
      restart_reg         <= 1'b0;
      present_reg         <= 1'b0;
      modulator_sample    <= 1'b0;
      modulator_reset     <= 1'b0;
      power_down          <= 1'b0;
      analog_input_select <= SEL_RESET;
    end else if (clk_en) begin
      state_reg           <= state_next;
      div_reg             <= div_next;
      settle_reg          <= settle_next;
      hold_reg            <= hold_next;
      restart_reg         <= restart_next;
      present_reg         <= present_next;
      modulator_sample    <= mod_stb_next;
      modulator_reset     <= mod_rst_next;
      power_down          <= pdown_next;
      analog_input_select <= select_next;
    end
  end

  sinc5_decimator u_filter (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .restart    (restart_reg),
    .sample_stb (modulator_sample),
    .bit_in     (modulator_bit),
    .result     (filt_result),
    .result_stb (filt_stb)
  );

  // -----------------------------------------------------------------
  // serial readout on the shared ready/data pin
  // -----------------------------------------------------------------
  assign shift_msb = shift_reg[RESULT_BITS-1];

  always_comb begin
    shift_next  = shift_reg;
    pin_next    = result_out_ready_pin;
    bit_next    = bit_reg;
    loaded_next = loaded_reg;
    if (restart_reg) begin
      pin_next    = PIN_IDLE;
      bit_next    = 5'h0;
      loaded_next = 1'b0;
    end else if (present_reg && bit_reg == 5'h0) begin
      shift_next  = filt_result;
      pin_next    = 1'b0;
      loaded_next = 1'b1;
    end else if (loaded_reg && sclk_rise &&
                 bit_reg != 5'(RESULT_BITS)) begin
      pin_next   = shift_msb;
      shift_next = {shift_reg[RESULT_BITS-2:0], 1'b0};
      bit_next   = bit_reg + 5'h1;
    end else if (loaded_reg && sclk_fall &&
                 bit_reg == 5'(RESULT_BITS)) begin
      pin_next    = PIN_IDLE;
      bit_next    = 5'h0;
      loaded_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg            <= '0;
      result_out_ready_pin <= PIN_IDLE;
      bit_reg              <= 5'h0;
      loaded_reg           <= 1'b0;
    end else if (clk_en) begin
      shift_reg            <= shift_next;
      result_out_ready_pin <= pin_next;
      bit_reg              <= bit_next;
      loaded_reg           <= loaded_next;
    end
  end

  // -----------------------------------------------------------------
  // checks and their helper counters
  // -----------------------------------------------------------------
  logic [8:0] per_cnt;
  logic       per_ok;
  logic [2:0] res_cnt;
  logic       steady;

  assign steady = running && !restart_next;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= 9'h0;
      per_ok  <= 1'b0;
      res_cnt <= 3'h0;
    end else if (clk_en) begin
      per_cnt <= (filt_stb || !steady) ? 9'h0 : per_cnt + 9'h1;
      per_ok  <= steady && (per_ok || filt_stb);
      if (restart_reg) begin
        res_cnt <= 3'h0;
      end else if (filt_stb && res_cnt != 3'h7) begin
        res_cnt <= res_cnt + 3'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ready_low_a: assert property (
    (clk_en && present_reg && bit_reg == 5'h0 && !restart_reg)
    |=> !result_out_ready_pin)
    else $error("ready not flagged after new word");

  pin_idle_a: assert property (
    !loaded_reg |-> result_out_ready_pin)
    else $error("pin low with no word pending");

  msb_first_a: assert property (
    (clk_en && loaded_reg && bit_reg == 5'h0 && sclk_rise &&
     !restart_reg && !present_reg)
    |=> (result_out_ready_pin == $past(shift_msb)) && bit_reg == 5'h1)
    else $error("first shift clock did not show the msb");

  shift_hold_a: assert property (
    (clk_en && !sclk_rise && !present_reg) |=> $stable(shift_reg))
    else $error("shift register moved without shift clock");

  mod_rate_a: assert property (
    (clk_en && modulator_sample && steady)
    ##1 (clk_en && steady && !modulator_sample)[*5]
    |=> modulator_sample)
    else $error("modulator strobe not every six clocks");

  conv_period_a: assert property (
    (clk_en && filt_stb && per_ok) |-> per_cnt == 9'(CONV_CYCLES - 1))
    else $error("conversion period not 384 clocks");

  settle_five_a: assert property (
    $fell(result_out_ready_pin) |-> res_cnt >= 3'(SETTLE_RESULTS))
    else $error("ready before five conversions");

  chan_restart_a: assert property (
    (clk_en && running && chan_change) |=> restart_reg && !present_reg)
    else $error("channel change did not restart conversion");

  chan_decode_a: assert property (
    $past(clk_en) |-> analog_input_select == (4'h1 << chan_stable_reg))
    else $error("input select does not match channel code");

  sync_reset_a: assert property (
    (clk_en && running && sclk_stable_reg &&
     hold_reg == 16'(SYNC_HOLD - 1)) |=> modulator_reset && restart_reg)
    else $error("held shift clock did not reset modulator");

endmodule
`default_nettype wire

// file: bench/host_reader.sv
// host model that drives the shift clock and reads result words
`timescale 1ns/10ps
`default_nettype none
module host_reader
  import adc_readout_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic data_pin,
  output var  logic shift_clk
);
  // -----------------------------------------------------------------
  // shift clock phases, both well above the three-flop sync delay
  // -----------------------------------------------------------------
  localparam int HIGH_CYCLES = 5;
  localparam int LOW_CYCLES  = 4;

  initial shift_clk = 1'b0;

  // -----------------------------------------------------------------
  // hold the shift clock at a level, high only for sync or sleep
  // -----------------------------------------------------------------
  task automatic hold_level(input logic v);
    @(posedge ref_clk);
    #1;
    shift_clk = v;
  endtask

  // -----------------------------------------------------------------
  // one rise per bit, bit taken as the clock falls, msb first
  // -----------------------------------------------------------------
  task automatic read_word(output logic [RESULT_BITS-1:0] w);
    for (int i = RESULT_BITS - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      #1;
      shift_clk = 1'b1;
      repeat (HIGH_CYCLES) @(posedge ref_clk);
      #1;
      w[i] = data_pin;
      shift_clk = 1'b0;
      repeat (LOW_CYCLES - 1) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the converter readout block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(act, exp) \
  begin check_count++; if ((act) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t act=%h exp=%h", $time, (act), (exp)); end end
module testbench
  import adc_readout_pkg::*;
;
  // -----------------------------------------------------------------
  // settings and signals
  // -----------------------------------------------------------------
  localparam int SYNC_H         = 20;
  localparam int PDOWN_H        = 60;
  localparam int TIMEOUT_CYCLES = 40000;
  localparam int SETTLE_MIN     = SETTLE_RESULTS * CONV_CYCLES;
  localparam int SETTLE_MAX     = SETTLE_MIN + 24;

  logic       ref_clk          = 1'b0;
  logic       rst_n            = 1'b0;
  logic       clk_en           = 1'b1;
  logic       shift_clk_pin;
  logic       channel_pick_lsb = 1'b0;
  logic       channel_pick_msb = 1'b0;
  logic       modulator_bit    = 1'b0;
  logic       result_out_ready_pin;
  logic [3:0] analog_input_select;
  logic       modulator_sample;
  logic       modulator_reset;
  logic       power_down;
  int         fail_count       = 0;
  int         check_count      = 0;
  int         cycles           = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  adc_readout #(.SYNC_HOLD(SYNC_H), .PDOWN_HOLD(PDOWN_H)) uut (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .clk_en               (clk_en),
    .shift_clk_pin        (shift_clk_pin),
    .channel_pick_lsb     (channel_pick_lsb),
    .channel_pick_msb     (channel_pick_msb),
    .modulator_bit        (modulator_bit),
    .result_out_ready_pin (result_out_ready_pin),
    .analog_input_select  (analog_input_select),
    .modulator_sample     (modulator_sample),
    .modulator_reset      (modulator_reset),
    .power_down           (power_down)
  );

  host_reader host (
    .ref_clk   (ref_clk),
    .data_pin  (result_out_ready_pin),
    .shift_clk (shift_clk_pin)
  );

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_pin(input logic v, input int lim, output int n);
    n = 0;
    while (result_out_ready_pin !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask

  task automatic set_channel(input logic [1:0] c);
    channel_pick_msb = c[1];
    channel_pick_lsb = c[0];
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic test_reset();
    `CHECK(result_out_ready_pin, PIN_IDLE)
    `CHECK(analog_input_select, SEL_RESET)
    `CHECK({modulator_sample, modulator_reset, power_down}, 3'h0)
  endtask

  // every code, each one a change from the last
  task automatic test_channels();
    logic [1:0] c;
    for (int i = 1; i <= 4; i++) begin
      c = 2'(i);
      set_channel(c);
      step(6);
      `CHECK(analog_input_select, 4'h1 << c)
    end
  endtask

  task automatic test_mod_rate();
    int n;
    n = 0;
    while (modulator_sample !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    step(1);
    n = 1;
    while (modulator_sample !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    `CHECK(n, MOD_DIV)
    // three frozen clocks stretch the next period by three
    step(1);
    clk_en = 1'b0;
    step(3);
    clk_en = 1'b1;
    n = 4;
    while (modulator_sample !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    `CHECK(n, MOD_DIV + 3)
  endtask

  // restart by channel change, settle, read, then next word
  task automatic test_settle_read(input logic bitv, input logic [1:0] ch,
                                  input logic [23:0] exp);
    int          n;
    int          m;
    logic [23:0] w;
    modulator_bit = bitv;
    set_channel(ch);
    // a word still pending is first dropped by the restart
    wait_pin(1'b1, 8, m);
    `CHECK(result_out_ready_pin, 1'b1)
    wait_pin(1'b0, SETTLE_MAX + 10, n);
    n = n + m;
    `CHECK(n >= SETTLE_MIN && n <= SETTLE_MAX, 1'b1)
    host.read_word(w);
    `CHECK(w, exp)
    step(6);
    `CHECK(result_out_ready_pin, 1'b1)
    wait_pin(1'b0, CONV_CYCLES, n);
    `CHECK(result_out_ready_pin, 1'b0)
  endtask

  // a channel change with a word pending drops that word
  task automatic test_drop(input logic [1:0] ch);
    `CHECK(result_out_ready_pin, 1'b0)
    set_channel(ch);
    step(8);
    `CHECK(result_out_ready_pin, 1'b1)
  endtask

  task automatic test_sync();
    int n;
    host.hold_level(1'b1);
    n = 0;
    while (modulator_reset !== 1'b1 && n < SYNC_H + 10) begin
      step(1);
      n++;
    end
    `CHECK(n >= SYNC_H && n <= SYNC_H + 6, 1'b1)
    `CHECK({result_out_ready_pin, power_down}, 2'h2)
    while (power_down !== 1'b1 && n < PDOWN_H + 10) begin
      step(1);
      n++;
    end
    `CHECK(n >= PDOWN_H && n <= PDOWN_H + 6, 1'b1)
    `CHECK(modulator_reset, 1'b0)
    host.hold_level(1'b0);
    step(6);
    `CHECK({modulator_reset, power_down}, 2'h0)
    wait_pin(1'b0, SETTLE_MAX + 10, n);
    `CHECK(n >= SETTLE_MIN - 10 && n <= SETTLE_MAX, 1'b1)
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    step(5);
    test_reset();
    rst_n = 1'b1;
    step(5);
    test_channels();
    test_mod_rate();
    test_settle_read(1'b0, 2'h1, 24'h800000);
    test_drop(2'h2);
    test_sync();
    // word pending is dropped here on purpose by the change
    test_settle_read(1'b1, 2'h3, 24'h7fffff);
    stop_test();
  end
endmodule
`default_nettype wire
